/* File: core/pmicio_top.v */
// i/o pin configuration, memory-reset path and buck default selection
// Functional notes
// - pin a open-drain from user bit when mode 0
// - mode 1, power good high: pass input through
// - power good low: hold the level latched while power good was high
// - mode 0, buffer 0: open-drain memory-reset output
// - mode 0, buffer 1: push-pull memory-reset output
// - mode 1: output ignores user bit, buffer selectable
// - output buffer type is nonvolatile setting
// - reset enable 0: pin c open-drain output
// - reset enable 1: pin c is reset input
// - band selects buck three power-up code
// - band selects buck four power-up code
// - other bands keep programmed default code
// - falling pin c restores bucks one, two
`default_nettype none
`include "pmicio_defines.vh"

module pmicio_top
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       mem_reset_mode_select,
  input  wire       out_buffer_type,
  input  wire       converter_reset_enable,
  input  wire       pin_a_user_bit,
  input  wire       pin_c_user_bit,
  input  wire       mem_reset_out_user_bit,
  input  wire       power_good_signal,
  input  wire       mem_reset_in_pin_i,
  input  wire       converter_reset_pin_i,
  input  wire       power_up_load,
  input  wire [2:0] resistor_band,
  input  wire [5:0] buck_three_prog_default,
  input  wire [5:0] buck_four_prog_default,
  output reg        mem_reset_in_pin_o,
  output reg        mem_reset_in_pin_oe,
  output reg        mem_reset_out_pin_o,
  output reg        mem_reset_out_pin_oe,
  output reg        converter_reset_pin_o,
  output reg        converter_reset_pin_oe,
  output reg        buck_one_two_restore,
  output reg  [5:0] buck_three_vsel,
  output reg  [5:0] buck_four_vsel
);

  // ----------------------------------------
  // timing overview
  // ----------------------------------------

  // every output leaves a flop, so each answer lands one edge after
  // the inputs that cause it are sampled
  // pin a and pin c pass two synchroniser flops first, so a pin a change
  // reaches the memory-reset output three edges later
  // a falling pin c shows as a restore pulse two edges after the
  // first flop samples it low
  // power good comes from inside the device and is used as it stands
  // reset drives the memory-reset output low and releases pins a and c
  // the buck codes read zero until the first power-up load
  // pin c needs two quiet cycles between edges; a shorter glitch may
  // be filtered by the synchroniser or give a single pulse
  // pins a and c carry a constant low data bit; only the enable
  // moves, so such a pin never drives high by accident

  // ----------------------------------------
  // functions
  // ----------------------------------------

  // band decode for buck three; unnamed bands keep the programmed code
  function [5:0] pmicio_b3_code;
    input [2:0] band;
    input [5:0] dflt;
    begin
      case (band)
        `PMICIO_BAND_12K1: pmicio_b3_code = `PMICIO_B3_CODE_12K1;
        `PMICIO_BAND_20K:  pmicio_b3_code = `PMICIO_B3_CODE_20K;
        `PMICIO_BAND_31K6: pmicio_b3_code = `PMICIO_B3_CODE_31K6;
        `PMICIO_BAND_45K3: pmicio_b3_code = `PMICIO_B3_CODE_45K3;
        default:           pmicio_b3_code = dflt;
      endcase
    end
  endfunction

  // band decode for buck four; 150k band also covers tie to supply
  function [5:0] pmicio_b4_code;
    input [2:0] band;
    input [5:0] dflt;
    begin
      case (band)
        `PMICIO_BAND_45K3: pmicio_b4_code = `PMICIO_B4_CODE_45K3;
        `PMICIO_BAND_64K9: pmicio_b4_code = `PMICIO_B4_CODE_64K9;
        `PMICIO_BAND_95K3: pmicio_b4_code = `PMICIO_B4_CODE_95K3;
        `PMICIO_BAND_150K: pmicio_b4_code = `PMICIO_B4_CODE_150K;
        default:           pmicio_b4_code = dflt;
      endcase
    end
  endfunction

  // open-drain enable: drive low only for a 0 while the pin is an output
  function pmicio_od_enable;
    input released;
    input level;
    begin
      pmicio_od_enable = !released && !level;
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------

  reg mem_in_meta;
  reg mem_in_sync;
  reg conv_meta;
  reg conv_sync;
  reg conv_sync_d;

  // pin a: two flops; only the second stage feeds the latch and output
  // idle level is high so the release of reset shows no false low
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_in_meta <= `PMICIO_PIN_IDLE;
      mem_in_sync <= `PMICIO_PIN_IDLE;
    end
    else
    begin
      mem_in_meta <= mem_reset_in_pin_i;
      mem_in_sync <= mem_in_meta;
    end
  end

  // pin c: two flops plus one history flop for the falling-edge test
  // history resets to the idle level, so reset alone never fires a restore
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      conv_meta   <= `PMICIO_PIN_IDLE;
      conv_sync   <= `PMICIO_PIN_IDLE;
      conv_sync_d <= `PMICIO_PIN_IDLE;
    end
    else
    begin
      conv_meta   <= converter_reset_pin_i;
      conv_sync   <= conv_meta;
      conv_sync_d <= conv_sync;
    end
  end

  // ----------------------------------------
  // memory-reset latch
  // ----------------------------------------

  reg mem_latch;
  reg next_mem_level;

  // latch follows the synced pin while power good is high and freezes
  // as soon as it drops, so it keeps the level of the falling edge;
  // a capture one edge later would let a pin change slip through
  always @(posedge clk)
  begin
    if (!rst_n)
      mem_latch <= `PMICIO_MEMRST_POR;
    else if (power_good_signal)
      mem_latch <= mem_in_sync;
  end

  // level seen by the memory-reset output in pass-through mode
  // power good is internal and already in this clock domain
  always @*
  begin
    if (power_good_signal)
      next_mem_level = mem_in_sync;
    else
      next_mem_level = mem_latch;
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------

  reg next_out_level;
  reg next_out_enable;
  reg next_pin_a_enable;
  reg next_pin_c_enable;

  // user bit only counts in general-purpose mode
  always @*
  begin
    if (mem_reset_mode_select)
      next_out_level = next_mem_level;
    else
      next_out_level = mem_reset_out_user_bit;
  end

  // push-pull always drives; open-drain only pulls low and floats high
  always @*
  begin
    if (out_buffer_type)
      next_out_enable = `PMICIO_DRIVE_ON;    // push-pull
    else
      next_out_enable = pmicio_od_enable(`PMICIO_MODE_OUTPUT, next_out_level);
  end

  // pin a is an input in memory-reset mode, so the user bit is dropped
  always @*
  begin
    next_pin_a_enable = pmicio_od_enable(mem_reset_mode_select, pin_a_user_bit);
  end

  // pin c is a reset input when enabled; the user bit is dropped then
  always @*
  begin
    next_pin_c_enable = pmicio_od_enable(converter_reset_enable, pin_c_user_bit);
  end

  // pin a driver; the data bit stays low, the enable does the work
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_reset_in_pin_o  <= `PMICIO_DRIVE_LOW;
      mem_reset_in_pin_oe <= `PMICIO_DRIVE_OFF;
    end
    else
    begin
      mem_reset_in_pin_o  <= `PMICIO_DRIVE_LOW;
      mem_reset_in_pin_oe <= next_pin_a_enable;
    end
  end

  // memory-reset output; reset drives it low so memory stays held
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_reset_out_pin_o  <= `PMICIO_MEMRST_POR;
      mem_reset_out_pin_oe <= `PMICIO_DRIVE_ON;
    end
    else
    begin
      mem_reset_out_pin_o  <= next_out_level;
      mem_reset_out_pin_oe <= next_out_enable;
    end
  end

  // pin c driver; same open-drain scheme as pin a
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      converter_reset_pin_o  <= `PMICIO_DRIVE_LOW;
      converter_reset_pin_oe <= `PMICIO_DRIVE_OFF;
    end
    else
    begin
      converter_reset_pin_o  <= `PMICIO_DRIVE_LOW;
      converter_reset_pin_oe <= next_pin_c_enable;
    end
  end

  // ----------------------------------------
  // buck restore and power-up defaults
  // ----------------------------------------

  reg next_restore;

  // synced falling edge of pin c while it acts as a reset input;
  // edges seen with the enable low are dropped, not queued
  always @*
  begin
    next_restore = converter_reset_enable && conv_sync_d && !conv_sync;
  end

  // one-cycle pulse; only bucks one and two act on it, nothing else resets
  always @(posedge clk)
  begin
    if (!rst_n)
      buck_one_two_restore <= `PMICIO_PULSE_IDLE;
    else
      buck_one_two_restore <= next_restore;
  end

  // the band is read while the load strobe is high; holding the strobe
  // keeps reloading, so the comparator must settle before it rises
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      buck_three_vsel <= `PMICIO_VSEL_POR;
      buck_four_vsel  <= `PMICIO_VSEL_POR;
    end
    else if (power_up_load)
    begin
      buck_three_vsel <= pmicio_b3_code(resistor_band, buck_three_prog_default);
      buck_four_vsel  <= pmicio_b4_code(resistor_band, buck_four_prog_default);
    end
  end

endmodule

`default_nettype wire

/* File: inc/pmicio_defines.vh */
// constants for the pmic i/o configuration and default select block
`ifndef PMICIO_DEFINES_VH
`define PMICIO_DEFINES_VH

// resistor band codes from the comparator
`define PMICIO_BAND_W       3
`define PMICIO_BAND_0K      3'h0
`define PMICIO_BAND_12K1    3'h1
`define PMICIO_BAND_20K     3'h2
`define PMICIO_BAND_31K6    3'h3
`define PMICIO_BAND_45K3    3'h4
`define PMICIO_BAND_64K9    3'h5
`define PMICIO_BAND_95K3    3'h6
`define PMICIO_BAND_150K    3'h7

// converter voltage field codes
`define PMICIO_VSEL_W       6
`define PMICIO_B3_CODE_12K1 6'h12
`define PMICIO_B3_CODE_20K  6'h18
`define PMICIO_B3_CODE_31K6 6'h1F
`define PMICIO_B3_CODE_45K3 6'h3D
`define PMICIO_B4_CODE_45K3 6'h01
`define PMICIO_B4_CODE_64K9 6'h07
`define PMICIO_B4_CODE_95K3 6'h0D
`define PMICIO_B4_CODE_150K 6'h14

// reset values
`define PMICIO_MEMRST_POR   1'h0
`define PMICIO_PIN_IDLE     1'h1
`define PMICIO_PULSE_IDLE   1'h0
`define PMICIO_VSEL_POR     6'h00

// pin driver levels
`define PMICIO_DRIVE_LOW    1'h0
`define PMICIO_DRIVE_ON     1'h1
`define PMICIO_DRIVE_OFF    1'h0
`define PMICIO_MODE_OUTPUT  1'h0

`endif

/* File: verification/pmicio_checker_assertions.sv */
// port checker for the pmic i/o block
`default_nettype none
module pmicio_checker
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       mem_reset_mode_select,
  input wire logic       out_buffer_type,
  input wire logic       converter_reset_enable,
  input wire logic       pin_a_user_bit,
  input wire logic       pin_c_user_bit,
  input wire logic       mem_reset_out_user_bit,
  input wire logic       power_good_signal,
  input wire logic       mem_reset_in_pin_i,
  input wire logic       converter_reset_pin_i,
  input wire logic       power_up_load,
  input wire logic       mem_reset_in_pin_oe,
  input wire logic       mem_reset_out_pin_o,
  input wire logic       mem_reset_out_pin_oe,
  input wire logic       converter_reset_pin_oe,
  input wire logic       buck_one_two_restore,
  input wire logic [2:0] resistor_band,
  input wire logic [5:0] buck_three_vsel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pin drive follows the user bits one edge later while the pin is an output, and stays off in input mode
  AST_PIN_A: assert property (!mem_reset_mode_select
    |=> mem_reset_in_pin_oe == !$past(pin_a_user_bit)) else $error("pin a drive wrong");
  AST_A_IN: assert property (mem_reset_mode_select
    |=> !mem_reset_in_pin_oe) else $error("pin a driven in input mode");
  AST_PIN_C: assert property (!converter_reset_enable
    |=> converter_reset_pin_oe == !$past(pin_c_user_bit)) else $error("pin c drive wrong");
  AST_C_IN: assert property (converter_reset_enable
    |=> !converter_reset_pin_oe) else $error("pin c driven in input mode");
  AST_OUT_USER: assert property (!mem_reset_mode_select |=>
    mem_reset_out_pin_oe == ($past(out_buffer_type) || !$past(mem_reset_out_user_bit))
    && (!mem_reset_out_pin_oe || mem_reset_out_pin_o == $past(mem_reset_out_user_bit)))
    else $error("output from user bit wrong");
  AST_PASS_HI: assert property ((mem_reset_mode_select && power_good_signal
    && mem_reset_in_pin_i)[*4] |=> mem_reset_out_pin_oe == $past(out_buffer_type)
    && (!mem_reset_out_pin_oe || mem_reset_out_pin_o)) else $error("pass high wrong");
  AST_PASS_LO: assert property ((mem_reset_mode_select && power_good_signal
    && !mem_reset_in_pin_i)[*4] |=> mem_reset_out_pin_oe && !mem_reset_out_pin_o)
    else $error("pass low wrong");
  // latched level must not move while power good is low
  AST_HOLD: assert property (mem_reset_mode_select && $past(mem_reset_mode_select)
    && !power_good_signal |=> $stable(mem_reset_out_pin_o)) else $error("latch moved");
  AST_PULSE: assert property (buck_one_two_restore
    |=> !buck_one_two_restore) else $error("restore longer than one cycle");
  AST_CAUSE: assert property (converter_reset_enable && $fell(converter_reset_pin_i)
    |-> ##[3:5] buck_one_two_restore) else $error("restore missing");
  AST_VSEL: assert property (power_up_load && resistor_band == 3'h3
    |=> buck_three_vsel == 6'h1F) else $error("band code wrong");
endmodule
bind pmicio_top pmicio_checker pmicio_checker_inst (.*);
`default_nettype wire

/* File: verification/pmicio_host.sv */
// host model driving the two reset pins
`default_nettype none
module pmicio_host
(
  input  wire logic a_val, c_val, a_oe, c_oe,
  output var logic  a_pin, c_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // wired lines: device low drive wins over the host level
  always_comb a_pin = a_oe ? 1'b0 : a_val;
  always_comb c_pin = c_oe ? 1'b0 : c_val;
endmodule
`default_nettype wire

/* File: verification/pmicio_top_bench.sv */
// self-checking bench for the pmic i/o block
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module pmicio_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, ms = 0, bt = 0, ce = 0, ua = 1, uc = 1, uo = 0, pg = 0;
  logic ha = 1, hc = 1, pul = 0, hit;
  logic [2:0] band = 3'h0;
  logic [5:0] p3 = 6'h2A, p4 = 6'h33, v3, v4;
  wire a_i, c_i, a_o, c_o, a_oe, c_oe, o, o_oe, rs;
  int fails = 0, comparisons = 0;
  pmicio_top pmicio_top_inst (.clk(clk), .rst_n(rst_n), .mem_reset_mode_select(ms),
    .out_buffer_type(bt), .converter_reset_enable(ce), .pin_a_user_bit(ua),
    .pin_c_user_bit(uc), .mem_reset_out_user_bit(uo), .power_good_signal(pg),
    .mem_reset_in_pin_i(a_i), .converter_reset_pin_i(c_i), .power_up_load(pul),
    .resistor_band(band), .buck_three_prog_default(p3), .buck_four_prog_default(p4),
    .mem_reset_in_pin_o(a_o), .mem_reset_in_pin_oe(a_oe), .mem_reset_out_pin_o(o),
    .mem_reset_out_pin_oe(o_oe), .converter_reset_pin_o(c_o), .converter_reset_pin_oe(c_oe),
    .buck_one_two_restore(rs), .buck_three_vsel(v3), .buck_four_vsel(v4));
  pmicio_host pmicio_host_inst (.a_val(ha), .c_val(hc), .a_oe(a_oe), .c_oe(c_oe),
    .a_pin(a_i), .c_pin(c_i));
  initial forever #25 clk = ~clk;
  // settle past the edge before looking
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded watch for the restore pulse
  task watch;
    hit = 0;
    repeat (8)
    begin
      cyc(1);
      if (rs === 1'b1) hit = 1;
    end
  endtask
  task t_pin;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk) {ua, uc} <= {2{i[0]}};
      cyc(2);
      `CHK(a_oe, !i[0])
      `CHK(c_oe, !i[0])
      `CHK({a_o, c_o}, 2'h0)
    end
    @(posedge clk) {ms, ce, ua, uc} <= 4'hC;
    cyc(2);
    `CHK({a_oe, c_oe}, 2'h0)
  endtask
  task t_out;
    @(posedge clk) ms <= 0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) {bt, uo} <= i[1:0];
      cyc(2);
      `CHK(o_oe, i[1] | ~i[0])
      if (o_oe === 1'b1) `CHK(o, i[0])
    end
  endtask
  task t_pass;
    @(posedge clk) {ms, pg, bt, ha, uo} <= 5'h1C;
    cyc(5);
    `CHK(o, 1'b0)
    @(posedge clk) ha <= 1;
    cyc(5);
    `CHK(o, 1'b1)
    // level must survive the host dropping the line after power good falls
    @(posedge clk) pg <= 0;
    @(posedge clk) ha <= 0;
    cyc(5);
    `CHK(o, 1'b1)
    @(posedge clk) bt <= 0;
    cyc(2);
    `CHK(o_oe, 1'b0)
  endtask
  task t_restore;
    @(posedge clk) {ce, uc, hc} <= 3'h6;
    watch();
    `CHK(hit, 1'b1)
    @(posedge clk) hc <= 1;
    cyc(3);
    @(posedge clk) ce <= 0;
    @(posedge clk) hc <= 0;
    watch();
    `CHK(hit, 1'b0)
  endtask
  task t_vsel;
    logic [5:0] e3 [8];
    logic [5:0] e4 [8];
    e3 = '{p3, 6'h12, 6'h18, 6'h1F, 6'h3D, p3, p3, p3};
    e4 = '{p4, p4, p4, p4, 6'h01, 6'h07, 6'h0D, 6'h14};
    for (int b = 0; b < 8; b++)
    begin
      @(posedge clk) {band, pul} <= {b[2:0], 1'b1};
      cyc(1);
      `CHK(v3, e3[b])
      `CHK(v4, e4[b])
    end
    @(posedge clk) pul <= 0;
  endtask
  task report_and_stop;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    t_pin();
    t_out();
    t_pass();
    t_restore();
    t_vsel();
    report_and_stop();
  end
endmodule
`default_nettype wire
